// [core/cms_avg.sv]
// Purpose: oversampling accumulator, reports the mean of the samples taken
// Assumes: sample count is a power of two given by its log
// Notes: clear and add in one cycle starts a fresh sum with that sample
`default_nettype none
module cms_avg
  import cms_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clr_in,
  input wire logic add_in,
  input wire logic [RES_W-1:0] sample_in,
  input wire logic [2:0] shift_in,
  output logic [RES_W-1:0] avg_out
);
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;

  always_comb
  begin
    acc_next = clr_in ? '0 : acc_reg;
    if (add_in)
    begin
      acc_next = acc_next + ACC_W'(sample_in);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      acc_reg <= '0;
    else
      acc_reg <= acc_next;
  end

  logic [ACC_W-1:0] shifted;
  assign shifted = acc_reg >> shift_in;
  assign avg_out = shifted[RES_W-1:0];
endmodule
`default_nettype wire

// [core/cms_pkg.sv]
// Purpose: shared constants and types for the cell monitor sample sequencer
// Assumes: 40 MHz clock, 14-bit converter results
// Notes: channels 0..15 are cells, 16..23 auxiliary analog channels
`default_nettype none
package cms_pkg;
  // ---------------------------------------------------------------
  // channel counts and widths
  // ---------------------------------------------------------------
  localparam int CELL_N = 16;
  localparam int AUX_N = 8;
  localparam int DIG_N = 6;
  localparam int ACH_N = 24;
  localparam int RES_W = 14;
  localparam int OSR_LOG_MAX = 5;
  localparam int ACC_W = RES_W + OSR_LOG_MAX;
  localparam int MAX_DEVICES = 6;
  localparam int CELLS_MAX = 96;
  localparam logic [4:0] CH_LAST = 5'h17;
  localparam logic [4:0] AUX_BASE = 5'h10;
  localparam logic [2:0] OSR_LOG_TOP = 3'h5;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam int SAMP_MIN_NS = 4130;
  localparam int SAMP_MAX_NS = 1000080;
  localparam int SAMP_MIN_CYC = (SAMP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAMP_MAX_CYC = SAMP_MAX_NS / CLK_NS;
  // ---------------------------------------------------------------
  // types and reset values
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [CELL_N-1:0] cell_uv;
    logic [CELL_N-1:0] cell_ov;
    logic [AUX_N-1:0] aux_uv;
    logic [AUX_N-1:0] aux_ov;
    logic [CELL_N-1:0] cmp_uv;
    logic [CELL_N-1:0] cmp_ov;
    logic [DIG_N-1:0] dig;
  } cms_fault_t;
  typedef struct packed {
    logic [ACH_N-1:0] chan_sel;
    logic [2:0] osr_log;
    logic [15:0] samp_cyc;
  } cms_seq_cfg_t;
  typedef struct packed {
    logic [RES_W-1:0] uv;
    logic [RES_W-1:0] ov;
  } cms_lim_t;
  typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_CONV, S_STORE} cms_state_t;
  localparam cms_fault_t FAULT_RST = '0;
endpackage
`default_nettype wire

// [core/cms_seq.sv]
// Purpose: conversion sequencer, limit checks and fault logic of a stack monitor
// Assumes: converter handshake runs on clk_in; pins and comparators are asynchronous
// Notes: fault flags stay set until cleared; a new event beats a clear
`default_nettype none
module cms_seq
  import cms_pkg::*;
#(
  parameter logic [15:0] SAMP_MAX_P = 16'(SAMP_MAX_CYC)
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire cms_seq_cfg_t seq_cfg_in,
  input wire cms_lim_t cell_lim_in,
  input wire cms_lim_t [AUX_N-1:0] aux_lim_in,
  input wire logic [DIG_N-1:0] dig_pin_in,
  input wire logic [DIG_N-1:0] dig_en_in,
  input wire logic [DIG_N-1:0] dig_rise_in,
  input wire logic [CELL_N-1:0] cmp_uv_pin_in,
  input wire logic [CELL_N-1:0] cmp_ov_pin_in,
  input wire cms_fault_t fault_mask_in,
  input wire cms_fault_t fault_clr_in,
  input wire logic wake_cmd_in,
  input wire logic sleep_cmd_in,
  input wire logic [2:0] dev_addr_in,
  input wire logic adc_done_in,
  input wire logic [RES_W-1:0] adc_data_in,
  input wire logic [4:0] rd_idx_in,
  output logic adc_start_out,
  output logic [4:0] adc_ch_out,
  output logic busy_out,
  output logic done_out,
  output logic [RES_W-1:0] rd_data_out,
  output cms_fault_t fault_flags_out,
  output logic fault_pin_out,
  output logic awake_out,
  output logic wake_fwd_out,
  output logic addr_ok_out
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // highest selected channel below lim; bit 5 says one was found
  function automatic logic [5:0] next_ch(input logic [ACH_N-1:0] sel, input int lim);
    logic [5:0] r;
    r = '0;
    for (int i = 0; i < ACH_N; i++)
    begin
      if (sel[i] && i < lim)
        r = {1'b1, 5'(i)};
    end
    return r;
  endfunction

  cms_state_t state_reg;
  cms_state_t state_next;
  logic [4:0] ch_reg;
  logic [15:0] cnt_reg;
  logic [5:0] os_reg;
  logic pd_reg;
  cms_fault_t fault_reg;
  cms_fault_t fault_set;
  logic [RES_W-1:0] res_mem [ACH_N];
  logic [RES_W-1:0] avg;
  logic [5:0] first_sel;
  logic [5:0] after_sel;
  logic [15:0] samp_eff;
  logic [2:0] osr_eff;
  logic [5:0] os_last;
  logic samp_end;
  logic conv_last;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [DIG_N-1:0] dig_s1;
  logic [DIG_N-1:0] dig_s2;
  logic [DIG_N-1:0] dig_prev;
  logic [CELL_N-1:0] cuv_s1;
  logic [CELL_N-1:0] cuv_s2;
  logic [CELL_N-1:0] cov_s1;
  logic [CELL_N-1:0] cov_s2;
  logic [1:0] dig_arm_reg;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      dig_s1 <= '0;
      dig_s2 <= '0;
      dig_prev <= '0;
      cuv_s1 <= '0;
      cuv_s2 <= '0;
      cov_s1 <= '0;
      cov_s2 <= '0;
    end
    else
    begin
      dig_s1 <= dig_pin_in;
      dig_s2 <= dig_s1;
      dig_prev <= dig_s2;
      cuv_s1 <= cmp_uv_pin_in;
      cuv_s2 <= cuv_s1;
      cov_s1 <= cmp_ov_pin_in;
      cov_s2 <= cov_s1;
    end
  end

  // edges count only once the chain holds real pin levels, so a pin
  // that idles high gives no false edge after reset
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      dig_arm_reg <= '0;
    else if (dig_arm_reg != 2'h3)
      dig_arm_reg <= dig_arm_reg + 2'h1;
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  assign first_sel = next_ch(seq_cfg_in.chan_sel, ACH_N);
  assign after_sel = next_ch(seq_cfg_in.chan_sel, int'(ch_reg));
  assign samp_eff = (seq_cfg_in.samp_cyc < 16'(SAMP_MIN_CYC)) ? 16'(SAMP_MIN_CYC) :
                    (seq_cfg_in.samp_cyc > SAMP_MAX_P) ? SAMP_MAX_P : seq_cfg_in.samp_cyc;
  assign osr_eff = (seq_cfg_in.osr_log > OSR_LOG_TOP) ? OSR_LOG_TOP : seq_cfg_in.osr_log;
  assign os_last = 6'((7'h01 << osr_eff) - 7'h01);
  assign samp_end = (cnt_reg == samp_eff - 16'h0001);
  assign conv_last = adc_done_in && (os_reg == os_last);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
        if (start_in && !pd_reg && first_sel[5])
          state_next = S_SETTLE;
      S_SETTLE:
        if (samp_end)
          state_next = S_CONV;
      S_CONV:
        if (conv_last)
          state_next = S_STORE;
        else if (adc_done_in)
          state_next = S_SETTLE;
      S_STORE:
        state_next = after_sel[5] ? S_SETTLE : S_IDLE;
      default:
        state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      state_reg <= S_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ch_reg <= CH_LAST;
      cnt_reg <= '0;
      os_reg <= '0;
    end
    else
    begin
      if (state_reg == S_IDLE)
        ch_reg <= first_sel[4:0];
      else if (state_reg == S_STORE)
        ch_reg <= after_sel[4:0];
      cnt_reg <= (state_reg == S_SETTLE && !samp_end) ? cnt_reg + 16'h0001 : '0;
      if (state_reg == S_STORE || state_reg == S_IDLE)
        os_reg <= '0;
      else if (state_reg == S_CONV && adc_done_in)
        os_reg <= os_reg + 6'h01;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      adc_start_out <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      adc_start_out <= (state_reg == S_SETTLE) && samp_end;
      done_out <= (state_reg == S_STORE) && !after_sel[5];
    end
  end

  assign adc_ch_out = ch_reg;
  assign busy_out = (state_reg != S_IDLE);

  cms_avg u_avg (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clr_in(state_reg == S_STORE || state_reg == S_IDLE),
    .add_in(state_reg == S_CONV && adc_done_in),
    .sample_in(adc_data_in),
    .shift_in(osr_eff),
    .avg_out(avg)
  );

  // ---------------------------------------------------------------
  // result store
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < ACH_N; i++)
        res_mem[i] <= '0;
      rd_data_out <= '0;
    end
    else
    begin
      if (state_reg == S_STORE)
        res_mem[ch_reg] <= avg;
      rd_data_out <= (rd_idx_in <= CH_LAST) ? res_mem[rd_idx_in] : '0;
    end
  end

  // ---------------------------------------------------------------
  // faults
  // ---------------------------------------------------------------
  always_comb
  begin
    fault_set = FAULT_RST;
    if (state_reg == S_STORE)
    begin
      if (ch_reg < AUX_BASE)
      begin
        fault_set.cell_uv[ch_reg[3:0]] = (avg < cell_lim_in.uv);
        fault_set.cell_ov[ch_reg[3:0]] = (avg > cell_lim_in.ov);
      end
      else
      begin
        fault_set.aux_uv[ch_reg[2:0]] = (avg <= aux_lim_in[ch_reg[2:0]].uv);
        fault_set.aux_ov[ch_reg[2:0]] = (avg >= aux_lim_in[ch_reg[2:0]].ov);
      end
    end
    fault_set.cmp_uv = cuv_s2;
    fault_set.cmp_ov = cov_s2;
    if (dig_arm_reg == 2'h3)
    begin
      fault_set.dig = dig_en_in & ((dig_rise_in & dig_s2 & ~dig_prev) |
                                   (~dig_rise_in & ~dig_s2 & dig_prev));
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      fault_reg <= FAULT_RST;
    else
      fault_reg <= (fault_reg & ~fault_clr_in) | fault_set;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      fault_pin_out <= 1'b0;
    else
      fault_pin_out <= |(fault_reg & fault_mask_in);
  end

  assign fault_flags_out = fault_reg;

  // ---------------------------------------------------------------
  // power state and chain
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pd_reg <= 1'b1;
      wake_fwd_out <= 1'b0;
      addr_ok_out <= 1'b0;
    end
    else
    begin
      if (wake_cmd_in)
        pd_reg <= 1'b0;
      else if (sleep_cmd_in)
        pd_reg <= 1'b1;
      wake_fwd_out <= wake_cmd_in;
      addr_ok_out <= (dev_addr_in < 3'(MAX_DEVICES));
    end
  end

  assign awake_out = !pd_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_pin_masked: assert property (@(posedge clk_in) disable iff (rst_in)
    fault_pin_out == $past(|(fault_reg & fault_mask_in)))
    else $error("fault pin does not follow masked faults");
  a_fault_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    (fault_reg != FAULT_RST && fault_clr_in == FAULT_RST) |=> ((fault_reg & $past(fault_reg)) == $past(fault_reg)))
    else $error("fault bit dropped without a clear");
  a_set_wins: assert property (@(posedge clk_in) disable iff (rst_in)
    (cuv_s2 != '0) |=> ((fault_reg.cmp_uv & $past(cuv_s2)) == $past(cuv_s2)))
    else $error("comparator fault lost to a clear");
  a_samp_min: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(adc_start_out) |-> $past(cnt_reg) >= 16'(SAMP_MIN_CYC - 1))
    else $error("conversion started before the minimum sample time");
  a_desc_order: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == S_STORE) |=> (state_reg != S_SETTLE || ch_reg < $past(ch_reg)))
    else $error("channels not converted in descending order");
  a_wake_exit: assert property (@(posedge clk_in) disable iff (rst_in)
    wake_cmd_in |=> (awake_out && wake_fwd_out))
    else $error("wake command did not leave power down");
  a_pd_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    (pd_reg && state_reg == S_IDLE) |=> state_reg == S_IDLE)
    else $error("sequence started while powered down");
  a_dig_edge: assert property (@(posedge clk_in) disable iff (rst_in)
    (dig_arm_reg == 2'h3 && dig_en_in[0] && dig_rise_in[0] == dig_s2[0] &&
     dig_s2[0] != dig_prev[0]) |=> fault_reg.dig[0])
    else $error("selected edge fault missed");
  a_osr_count: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == S_STORE) |-> $past(os_reg) == os_last)
    else $error("store without the full oversample count");
endmodule
`default_nettype wire

// [testbench/cms_adc_model.sv]
// Purpose: converter stand-in that answers each start pulse with one sample
// Assumes: start pulse is one cycle wide; data is valid only with the done pulse
// Notes: answer delay varies 0..5 cycles; data line scrambled outside the pulse
`default_nettype none
module cms_adc_model
  import cms_pkg::*;
(
  input wire logic clk_in,
  input wire logic adc_start_in,
  output logic adc_done_out,
  output logic [RES_W-1:0] adc_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int lat;
  initial
  begin
    adc_done_out = 1'b0;
    adc_data_out = 14'h0000;
    forever
    begin
      @(posedge clk_in);
      #1;
      if (adc_start_in === 1'b1)
      begin
        lat = $urandom_range(0, 5);
        repeat (lat) @(posedge clk_in);
        #4 adc_done_out = 1'b1;
        adc_data_out = RES_W'($urandom);
        @(posedge clk_in);
        #4 adc_done_out = 1'b0;
        // stale data must not look valid once the pulse is over
        adc_data_out = ~adc_data_out;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/cms_seq_tb.sv]
// Purpose: self-checking bench for the stack monitor sequencer
// Assumes: converter stand-in cms_adc_model; sample time ceiling cut to 300 cycles
// Notes: expected results rebuilt from the samples seen on the converter lines
`default_nettype none
module cms_seq_tb
  import cms_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SMAX = 300;
  logic clk_in, rst_in, start_in, wake_cmd_in, sleep_cmd_in, adc_done_in, adc_start_out;
  logic busy_out, done_out, fault_pin_out, awake_out, wake_fwd_out, addr_ok_out;
  cms_seq_cfg_t seq_cfg_in;
  cms_lim_t cell_lim_in;
  cms_lim_t [AUX_N-1:0] aux_lim_in;
  logic [DIG_N-1:0] dig_pin_in, dig_en_in, dig_rise_in;
  logic [CELL_N-1:0] cmp_uv_pin_in, cmp_ov_pin_in;
  cms_fault_t fault_mask_in, fault_clr_in, fault_flags_out, exp_flt;
  logic [2:0] dev_addr_in;
  logic [RES_W-1:0] adc_data_in, rd_data_out;
  logic [4:0] rd_idx_in, adc_ch_out;
  logic [95:0] rnd;
  int n_fail, total_checks, j, k;
  int exp_mem [32];

  cms_seq #(.SAMP_MAX_P(16'(SMAX))) cms_seq_inst (.clk_in, .rst_in, .start_in, .seq_cfg_in,
    .cell_lim_in, .aux_lim_in, .dig_pin_in, .dig_en_in, .dig_rise_in, .cmp_uv_pin_in,
    .cmp_ov_pin_in, .fault_mask_in, .fault_clr_in, .wake_cmd_in, .sleep_cmd_in, .dev_addr_in,
    .adc_done_in, .adc_data_in, .rd_idx_in, .adc_start_out, .adc_ch_out, .busy_out, .done_out,
    .rd_data_out, .fault_flags_out, .fault_pin_out, .awake_out, .wake_fwd_out, .addr_ok_out);
  cms_adc_model cms_adc_model_inst (.clk_in(clk_in), .adc_start_in(adc_start_out),
    .adc_done_out(adc_done_in), .adc_data_out(adc_data_in));

  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk_in);
    #2;
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic clr_all();
    fault_clr_in = '1;
    tick();
    fault_clr_in = '0;
    exp_flt = FAULT_RST;
    tick();
    chk(fault_flags_out, exp_flt);
  endtask
  task automatic run_seq(input logic [23:0] sel, input int osr, input int samp);
    int sh, eff, n, ci, si, c;
    int chl[$];
    logic [31:0] sum;
    logic [RES_W-1:0] avg;
    sh = osr > 5 ? 5 : osr;
    eff = samp < 166 ? 166 : (samp > SMAX ? SMAX : samp);
    for (int i = 23; i >= 0; i--)
      if (sel[i])
        chl.push_back(i);
    seq_cfg_in = '{chan_sel: sel, osr_log: 3'(osr), samp_cyc: 16'(samp)};
    start_in = 1'b1;
    tick();
    start_in = 1'b0;
    n = 0;
    ci = 0;
    si = 0;
    sum = 0;
    while (done_out !== 1'b1 && n < 60000)
    begin
      tick();
      n++;
      if (adc_start_out === 1'b1)
      begin
        if (ci == 0 && si == 0)
          chk(n, eff);
        chk(adc_ch_out, chl[ci]);
      end
      if (adc_done_in === 1'b1)
      begin
        sum += adc_data_in;
        si++;
        if (si == (1 << sh))
        begin
          c = chl[ci];
          avg = RES_W'(sum >> sh);
          exp_mem[c] = avg;
          if (c < 16 && avg < cell_lim_in.uv)
            exp_flt.cell_uv[c] = 1'b1;
          if (c < 16 && avg > cell_lim_in.ov)
            exp_flt.cell_ov[c] = 1'b1;
          if (c >= 16 && avg <= aux_lim_in[c-16].uv)
            exp_flt.aux_uv[c-16] = 1'b1;
          if (c >= 16 && avg >= aux_lim_in[c-16].ov)
            exp_flt.aux_ov[c-16] = 1'b1;
          ci++;
          si = 0;
          sum = 0;
        end
      end
    end
    chk(ci, chl.size());
    tick();
    chk(fault_flags_out, exp_flt);
    chk(fault_pin_out, |(exp_flt & fault_mask_in));
    for (int i = 0; i < 32; i++)
    begin
      rd_idx_in = 5'(i);
      tick();
      chk(rd_data_out, i < 24 ? exp_mem[i] : 0);
    end
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (95000) @(posedge clk_in);
    n_fail++;
    complete_run();
  end
  initial
  begin
    n_fail = 0;
    total_checks = 0;
    rst_in = 1'b1;
    {start_in, wake_cmd_in, sleep_cmd_in} = 3'h0;
    seq_cfg_in = '0;
    cell_lim_in = '{uv: 14'h1000, ov: 14'h3000};
    aux_lim_in = '0;
    {dig_pin_in, dig_en_in, dig_rise_in} = '0;
    {cmp_uv_pin_in, cmp_ov_pin_in} = '0;
    {fault_mask_in, fault_clr_in, exp_flt} = '0;
    dev_addr_in = 3'h0;
    rd_idx_in = 5'h00;
    void'($urandom(32'h4A2BCC35));
    repeat (12) @(posedge clk_in);
    #2 rst_in = 1'b0;
    chk({awake_out, busy_out, adc_ch_out}, {2'h0, CH_LAST});
    for (int i = 0; i < 3; i++)
    begin
      seq_cfg_in.chan_sel = i == 2 ? 24'h000000 : 24'hFFFFFF;
      sleep_cmd_in = i == 1;
      tick();
      sleep_cmd_in = 1'b0;
      start_in = 1'b1;
      tick();
      start_in = 1'b0;
      tick();
      chk({busy_out, awake_out}, {1'b0, i == 2});
      wake_cmd_in = 1'b1;
      tick();
      wake_cmd_in = 1'b0;
      chk({awake_out, wake_fwd_out}, 2'h3);
      tick();
      chk(wake_fwd_out, 1'b0);
    end
    for (int a = 0; a < 8; a++)
    begin
      dev_addr_in = 3'(a);
      tick();
      chk(addr_ok_out, a < 6);
    end
    $display("test wake and address done");
    for (int t = 0; t < 7; t++)
    begin
      rnd = {$urandom, $urandom, $urandom};
      fault_mask_in = rnd[85:0];
      for (int a = 0; a < AUX_N; a++)
        aux_lim_in[a] = '{uv: 14'($urandom_range(0, 8191)), ov: 14'($urandom_range(8192, 16383))};
      run_seq(t == 0 ? 24'hFFFFFF : 24'($urandom) & 24'h810041 | 24'h000001, t,
        t == 1 ? 400 : (t < 3 ? $urandom_range(0, 400) : 0));
      if (t == 3)
        clr_all();
      $display("test sequence %0d done", t);
    end
    clr_all();
    k = $urandom_range(0, 15);
    j = 15 - k;
    fault_mask_in = FAULT_RST;
    fault_mask_in.cmp_ov[k] = 1'b1;
    cmp_uv_pin_in[j] = 1'b1;
    repeat (5) tick();
    chk({fault_flags_out.cmp_uv[j], fault_pin_out}, 2'h2);
    cmp_ov_pin_in[k] = 1'b1;
    repeat (5) tick();
    chk({fault_flags_out.cmp_ov[k], fault_pin_out}, 2'h3);
    fault_clr_in = '1;
    tick();
    fault_clr_in = '0;
    repeat (2) tick();
    chk(fault_flags_out.cmp_ov[k], 1'b1);
    {cmp_uv_pin_in, cmp_ov_pin_in} = '0;
    repeat (4) tick();
    clr_all();
    tick();
    chk(fault_pin_out, 1'b0);
    $display("test comparator bank done");
    dig_en_in = 6'($urandom) | 6'h01;
    dig_rise_in = 6'($urandom);
    dig_pin_in = ~dig_rise_in;
    repeat (5) tick();
    chk(fault_flags_out.dig, 6'h00);
    dig_pin_in = dig_rise_in;
    repeat (5) tick();
    chk(fault_flags_out.dig, dig_en_in);
    clr_all();
    dig_pin_in = ~dig_rise_in;
    repeat (5) tick();
    chk(fault_flags_out.dig, 6'h00);
    $display("test digital inputs done");
    complete_run();
  end
endmodule
`default_nettype wire
